/* File: pkg/pal_params.svh */
`ifndef PAL_PARAMS_SVH
`define PAL_PARAMS_SVH
// ****************************************
// Register offsets and fields
// ****************************************
`define PAL_OFS_BMC 5'h00
`define PAL_OFS_LDC 5'h18
`define PAL_OFS_PCC 5'h19
`define PAL_BMC_ISO_BIT 10
`define PAL_PCC_ADDR_MSB 4
`define PAL_PCC_CFG0_BIT 5
`define PAL_PCC_CFG1_BIT 6
`define PAL_LDC_VAL_LSB 0
`define PAL_LDC_EN_LSB 3
// ****************************************
// Reset values and counts
// ****************************************
`define PAL_ADDR_DEFAULT 5'h01
`define PAL_ADDR_ISO 5'h00
`define PAL_NLP_MIN 3'h7
`define PAL_CLK_KHZ 40000
`define PAL_LINK_LOSS_US 50000
`define PAL_BLINK_US 100000
`endif

/* File: pkg/pal_pkg.sv */
package pal_pkg;
    typedef struct packed {
        logic req;
        logic wr;
        logic [4:0] phy;
        logic [4:0] reg_idx;
        logic [15:0] wdata;
    } pal_mgmt_req_s;
    typedef struct packed {
        logic tx_clk;
        logic rx_clk;
        logic rx_dv;
        logic rx_er;
        logic [3:0] rxd;
        logic col;
        logic crs;
    } pal_mii_out_s;
    typedef struct packed {
        logic sig_detect;
        logic nlp;
        logic pkt_10;
        logic speed_100;
        logic full_dup;
        logic tx_act;
        logic rx_act;
        logic coll;
    } pal_line_s;
    typedef enum logic [1:0] {
        PAL_MODE1 = 2'b01,
        PAL_MODE2 = 2'b00,
        PAL_MODE3 = 2'b10
    } pal_mode_e;
endpackage

/* File: logic/pal_ctrl.sv */
`timescale 1ns/1ps
`include "pal_params.svh"
module pal_ctrl #(
    parameter int LOSS_CYC = `PAL_LINK_LOSS_US * (`PAL_CLK_KHZ / 1000),
    parameter int BLINK_CYC = `PAL_BLINK_US * (`PAL_CLK_KHZ / 1000)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input pal_pkg::pal_mgmt_req_s mgmt_req,
    output logic mgmt_ack,
    output logic [15:0] mgmt_rdata,
    input wire logic [3:0] rxd_in,
    input wire logic col_in,
    input pal_pkg::pal_mii_out_s mii_int,
    output pal_pkg::pal_mii_out_s mii_out,
    output logic mii_oe,
    input wire logic tx_en_in,
    input wire logic [3:0] txd_in,
    output logic tx_en_core,
    output logic [3:0] txd_core,
    output logic line_pkt_enable,
    input pal_pkg::pal_line_s line,
    output logic link_good,
    input wire logic indicator_mode_select_strap,
    input wire logic [2:0] led_in,
    output logic [2:0] led_out,
    output logic [2:0] led_oe
);
    import pal_pkg::*;

    // ****************************************
    // Strap capture
    // ****************************************
    logic rst_q_reg;
    logic [4:0] addr_reg;
    logic [4:0] addr_next;
    logic strap_iso_reg;
    logic [2:0] led_pol_reg;
    logic [1:0] cfg_reg;
    logic [1:0] cfg_next;
    logic bmc_iso_reg;
    logic bmc_iso_next;
    logic [5:0] ldc_reg;
    logic [5:0] ldc_next;
    wire logic capture = rst_q_reg & ~rst;
    wire logic [4:0] strap_addr = {rxd_in, col_in};

    // ****************************************
    // Management access
    // ****************************************
    wire logic hit = mgmt_req.req & (mgmt_req.phy == addr_reg);
    wire logic wr_hit = hit & mgmt_req.wr;
    wire logic sel_bmc = mgmt_req.reg_idx == `PAL_OFS_BMC;
    wire logic sel_ldc = mgmt_req.reg_idx == `PAL_OFS_LDC;
    wire logic sel_pcc = mgmt_req.reg_idx == `PAL_OFS_PCC;
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (sel_bmc) begin
            rd_val[`PAL_BMC_ISO_BIT] = bmc_iso_reg;
        end else if (sel_ldc) begin
            rd_val[5:0] = ldc_reg;
        end else if (sel_pcc) begin
            rd_val[`PAL_PCC_ADDR_MSB:0] = addr_reg;
            rd_val[`PAL_PCC_CFG1_BIT:`PAL_PCC_CFG0_BIT] = cfg_reg;
        end
    end
    // Address write never touches the strap isolate flag
    assign addr_next = (wr_hit & sel_pcc) ? mgmt_req.wdata[`PAL_PCC_ADDR_MSB:0] : addr_reg;
    assign cfg_next = (wr_hit & sel_pcc) ?
        mgmt_req.wdata[`PAL_PCC_CFG1_BIT:`PAL_PCC_CFG0_BIT] : cfg_reg;
    assign bmc_iso_next = (wr_hit & sel_bmc) ? mgmt_req.wdata[`PAL_BMC_ISO_BIT] : bmc_iso_reg;
    assign ldc_next = (wr_hit & sel_ldc) ? mgmt_req.wdata[5:0] : ldc_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rst_q_reg <= 1'b1;
            addr_reg <= `PAL_ADDR_DEFAULT;
            strap_iso_reg <= 1'b0;
            led_pol_reg <= 3'h0;
            cfg_reg <= 2'b01;
            bmc_iso_reg <= 1'b0;
            ldc_reg <= 6'h00;
            mgmt_ack <= 1'b0;
            mgmt_rdata <= 16'h0000;
        end else begin
            rst_q_reg <= 1'b0;
            mgmt_ack <= hit;
            mgmt_rdata <= hit ? rd_val : 16'h0000;
            bmc_iso_next_apply: begin
            end
            bmc_iso_reg <= bmc_iso_next;
            ldc_reg <= ldc_next;
            if (capture) begin
                addr_reg <= strap_addr;
                strap_iso_reg <= strap_addr == `PAL_ADDR_ISO;
                led_pol_reg <= led_in;
                cfg_reg <= {cfg_reg[1], indicator_mode_select_strap};
            end else begin
                addr_reg <= addr_next;
                cfg_reg <= cfg_next;
            end
        end
    end

    // ****************************************
    // Isolate
    // ****************************************
    wire logic isolate = strap_iso_reg | bmc_iso_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mii_out <= '0;
            mii_oe <= 1'b0;
            tx_en_core <= 1'b0;
            txd_core <= 4'h0;
            line_pkt_enable <= 1'b0;
        end else begin
            // Pins stay inputs through the capture cycle so straps read cleanly
            mii_out <= mii_int;
            mii_oe <= ~isolate & ~capture;
            tx_en_core <= tx_en_in & ~isolate;
            txd_core <= isolate ? 4'h0 : txd_in;
            line_pkt_enable <= ~isolate;
        end
    end

    // ****************************************
    // Link detection
    // ****************************************
    // Runs regardless of isolate; isolate cuts off only the MII side and line_pkt_enable
    logic [2:0] nlp_cnt_reg;
    logic [31:0] loss_cnt_reg;
    wire logic sig_seen = line.speed_100 ? line.sig_detect : (line.nlp | line.pkt_10);
    wire logic link_up = line.speed_100 ? line.sig_detect :
        (line.pkt_10 | (line.nlp & (nlp_cnt_reg >= `PAL_NLP_MIN - 3'h1)));
    wire logic loss_exp = loss_cnt_reg >= 32'(LOSS_CYC - 1);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nlp_cnt_reg <= 3'h0;
            loss_cnt_reg <= 32'h0000_0000;
            link_good <= 1'b0;
        end else begin
            loss_cnt_reg <= (sig_seen | loss_exp) ? 32'h0000_0000 : loss_cnt_reg + 32'h0000_0001;
            if (loss_exp | line.speed_100) begin
                nlp_cnt_reg <= 3'h0;
            end else if (line.nlp & (nlp_cnt_reg != `PAL_NLP_MIN)) begin
                nlp_cnt_reg <= nlp_cnt_reg + 3'h1;
            end
            if (link_up) begin
                link_good <= 1'b1;
            end else if (loss_exp) begin
                link_good <= 1'b0;
            end
        end
    end

    // ****************************************
    // Indicators
    // ****************************************
    // Fixed period, long enough to be visible by eye
    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    wire logic act = line.tx_act | line.rx_act;
    always_ff @(posedge ref_clk) begin
        if (rst | ~act) begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
        end
    end

    wire logic coll_src = (~line.speed_100 & ~line.full_dup) ? mii_int.col : line.coll;
    pal_mode_e mode;
    assign mode = cfg_reg[0] ? PAL_MODE1 : pal_mode_e'(cfg_reg);
    logic [2:0] led_val;
    always_comb begin
        led_val[1] = line.speed_100;
        case (mode)
            PAL_MODE1: begin
                led_val[0] = link_good;
                led_val[2] = act;
            end
            PAL_MODE2: begin
                led_val[0] = link_good & ~(act & blink_reg);
                led_val[2] = coll_src;
            end
            default: begin
                led_val[0] = link_good & ~(act & blink_reg);
                led_val[2] = line.full_dup;
            end
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_led
            wire logic eff = ldc_reg[`PAL_LDC_EN_LSB + gi] ?
                ldc_reg[`PAL_LDC_VAL_LSB + gi] : led_val[gi];
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    led_out[gi] <= 1'b0;
                    led_oe[gi] <= 1'b0;
                end else begin
                    led_out[gi] <= eff ^ led_pol_reg[gi];
                    led_oe[gi] <= ~capture;
                end
            end
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    property p_addr_filter;
        @(posedge ref_clk) disable iff (rst)
        mgmt_req.req && mgmt_req.phy != addr_reg |=> !mgmt_ack;
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("ack at foreign address");

    property p_strap_cap;
        @(posedge ref_clk) disable iff (rst)
        capture |=> addr_reg == $past(strap_addr) && led_pol_reg == $past(led_in);
    endproperty
    a_strap_cap: assert property (p_strap_cap) else $error("straps not captured");

    property p_zero_iso;
        @(posedge ref_clk) disable iff (rst)
        capture && strap_addr == 5'h00 |=> ##1 !mii_oe && !line_pkt_enable;
    endproperty
    a_zero_iso: assert property (p_zero_iso) else $error("zero strap not isolated");

    property p_wr_zero;
        @(posedge ref_clk) disable iff (rst)
        !isolate && wr_hit && sel_pcc && mgmt_req.wdata[4:0] == 5'h00 && !(wr_hit && sel_bmc)
        |=> !isolate && addr_reg == 5'h00;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("address write isolated");

    property p_iso_tx;
        @(posedge ref_clk) disable iff (rst)
        isolate |=> !tx_en_core && !mii_oe;
    endproperty
    a_iso_tx: assert property (p_iso_tx) else $error("isolate leaks MII");

    property p_iso_mgmt;
        @(posedge ref_clk) disable iff (rst)
        isolate && hit |=> mgmt_ack;
    endproperty
    a_iso_mgmt: assert property (p_iso_mgmt) else $error("isolate blocks management");

    property p_rate;
        @(posedge ref_clk) disable iff (rst)
        !capture && !ldc_reg[`PAL_LDC_EN_LSB + 1] |=> led_out[1] == ($past(line.speed_100) ^ led_pol_reg[1]);
    endproperty
    a_rate: assert property (p_rate) else $error("rate indicator wrong");

    property p_link_hold;
        @(posedge ref_clk) disable iff (rst)
        link_good && !loss_exp |=> link_good;
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("link dropped early");
endmodule

/* File: verif/pal_pads.sv */
`timescale 1ns/1ps
// ****
// Shared strap pads, external resistors
// ****
module pal_pads (
    input wire logic [4:0] addr_strap,
    input wire logic [2:0] led_strap,
    input pal_pkg::pal_mii_out_s mii_out,
    input wire logic mii_oe,
    input wire logic [2:0] led_out,
    input wire logic [2:0] led_oe,
    output logic [3:0] rxd_in,
    output logic col_in,
    output logic [2:0] led_in
);
    import pal_pkg::*;
    // Released pads settle to resistor level, never the last driven value
    assign rxd_in = mii_oe ? mii_out.rxd : addr_strap[4:1];
    assign col_in = mii_oe ? mii_out.col : addr_strap[0];
    assign led_in = (led_oe & led_out) | (~led_oe & led_strap);
endmodule

/* File: verif/tb_phy_addr_isolate_led_ctrl.sv */
`timescale 1ns/1ps
`include "pal_params.svh"
module tb_phy_addr_isolate_led_ctrl;
    import pal_pkg::*;
    // ****
    // Signals
    // ****
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pal_mgmt_req_s mgmt_req = '0;
    pal_mii_out_s mii_int = 10'h2A5;
    pal_line_s line = '0;
    pal_mii_out_s mii_out;
    logic mgmt_ack, mii_oe, tx_en_core, line_pkt_enable, link_good, col_in;
    logic tx_en_in = 1'b1;
    logic [3:0] txd_in = 4'hA;
    logic [15:0] mgmt_rdata;
    logic [3:0] rxd_in, txd_core;
    logic [2:0] led_in, led_out, led_oe;
    logic [4:0] addr_strap = 5'h01;
    logic [2:0] led_strap = 3'h0;
    logic indicator_mode_select_strap = 1'b1;
    int miscompares = 0;
    int num_checks = 0;
    int zeros;
    always #12.5 ref_clk = ~ref_clk;
    pal_ctrl #(.LOSS_CYC(16), .BLINK_CYC(8)) i_pal_ctrl (.ref_clk(ref_clk), .rst(rst), .mgmt_req(mgmt_req),
        .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .rxd_in(rxd_in), .col_in(col_in), .mii_int(mii_int),
        .mii_out(mii_out), .mii_oe(mii_oe), .tx_en_in(tx_en_in), .txd_in(txd_in), .tx_en_core(tx_en_core),
        .txd_core(txd_core), .line_pkt_enable(line_pkt_enable), .line(line), .link_good(link_good),
        .indicator_mode_select_strap(indicator_mode_select_strap), .led_in(led_in), .led_out(led_out), .led_oe(led_oe));
    pal_pads i_pal_pads (.addr_strap(addr_strap), .led_strap(led_strap), .mii_out(mii_out), .mii_oe(mii_oe),
        .led_out(led_out), .led_oe(led_oe), .rxd_in(rxd_in), .col_in(col_in), .led_in(led_in));
    // ****
    // Tasks
    // ****
    task results;
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk1(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h", $time, m, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Ack rises on the taking edge itself and is checked 1 ns later
    task access(input logic wr, input logic [4:0] phy, input logic [4:0] ri, input logic [15:0] wd,
                input logic ack_exp, input logic [15:0] rd_exp);
        @(posedge ref_clk);
        mgmt_req <= '{1'b1, wr, phy, ri, wd};
        @(posedge ref_clk);
        mgmt_req.req <= 1'b0;
        #1;
        chk1(mgmt_ack, ack_exp, "ack");
        if (ack_exp && !wr) begin
            chk16(mgmt_rdata, rd_exp, "rdata");
        end
    endtask
    // Straps must hold across the capture edge after release
    task do_reset(input logic [4:0] a, input logic [2:0] l);
        @(posedge ref_clk);
        addr_strap <= a;
        led_strap <= l;
        rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        tick(4);
    endtask
    task pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            line.nlp <= 1'b1;
            @(posedge ref_clk);
            line.nlp <= 1'b0;
        end
        tick(3);
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        #500000;
        miscompares++;
        results();
    end
    initial begin
        do_reset(5'h01, 3'h0);
        chk1(mii_oe, 1'b1, "mii oe");
        chk16({6'h0, mii_out}, {6'h0, mii_int}, "mii out");
        chk1(tx_en_core & line_pkt_enable, 1'b1, "tx path");
        chk16({12'h0, txd_core}, 16'h000A, "txd path");
        chk16({13'h0, led_oe}, 16'h0007, "led oe");
        access(0, 5'h01, `PAL_OFS_PCC, 16'h0, 1, 16'h0021);
        access(0, 5'h02, `PAL_OFS_PCC, 16'h0, 0, 16'h0);
        pulses(6);
        chk1(led_out[0], 1'b0, "six pulses");
        pulses(1);
        chk1(led_out[0], 1'b1, "link on");
        tick(8);
        chk1(led_out[0], 1'b1, "link held");
        tick(12);
        chk1(led_out[0], 1'b0, "link lost");
        @(posedge ref_clk);
        line.speed_100 <= 1'b1;
        line.sig_detect <= 1'b1;
        line.tx_act <= 1'b1;
        tick(4);
        chk16({13'h0, led_out}, 16'h0007, "mode 1");
        line.tx_act <= 1'b0;
        line.coll <= 1'b1;
        access(1, 5'h01, `PAL_OFS_PCC, 16'h0001, 1, 16'h0);
        tick(3);
        chk1(led_out[2], 1'b1, "collision");
        line.rx_act <= 1'b1;
        zeros = 0;
        repeat (20) begin
            tick(1);
            zeros += (led_out[0] === 1'b0);
        end
        chk1(zeros > 0 && zeros < 20, 1'b1, "blink");
        line.rx_act <= 1'b0;
        tick(4);
        chk1(led_out[0], 1'b1, "steady");
        line.coll <= 1'b0;
        line.full_dup <= 1'b1;
        access(1, 5'h01, `PAL_OFS_PCC, 16'h0041, 1, 16'h0);
        tick(3);
        chk1(led_out[2], 1'b1, "full duplex");
        line.speed_100 <= 1'b0;
        line.full_dup <= 1'b0;
        mii_int.col <= 1'b1;
        access(1, 5'h01, `PAL_OFS_PCC, 16'h0001, 1, 16'h0);
        tick(3);
        chk16({13'h0, led_out}, 16'h0005, "mii col");
        access(1, 5'h01, `PAL_OFS_LDC, 16'h001A, 1, 16'h0);
        tick(2);
        chk16({13'h0, led_out}, 16'h0006, "direct");
        access(0, 5'h01, `PAL_OFS_LDC, 16'h0, 1, 16'h001A);
        access(1, 5'h01, `PAL_OFS_PCC, 16'h0020, 1, 16'h0);
        tick(2);
        chk1(mii_oe, 1'b1, "no isolate");
        access(0, 5'h00, `PAL_OFS_PCC, 16'h0, 1, 16'h0020);
        line.speed_100 <= 1'b1;
        access(1, 5'h00, `PAL_OFS_BMC, 16'h0400, 1, 16'h0);
        tick(3);
        chk1(mii_oe, 1'b0, "isolated");
        chk1(tx_en_core | line_pkt_enable, 1'b0, "tx blocked");
        chk16({12'h0, txd_core}, 16'h0000, "txd blocked");
        chk1(link_good, 1'b1, "link kept");
        access(0, 5'h00, `PAL_OFS_BMC, 16'h0, 1, 16'h0400);
        @(posedge ref_clk);
        line <= '0;
        indicator_mode_select_strap <= 1'b0;
        mii_int.col <= 1'b0;
        do_reset(5'h00, 3'h7);
        chk1(mii_oe, 1'b0, "strap isolate");
        chk16({13'h0, led_out}, 16'h0007, "polarity");
        access(0, 5'h00, `PAL_OFS_PCC, 16'h0, 1, 16'h0000);
        results();
    end
endmodule
